// ===== verilog/ucr_pkg.sv
package ucr_pkg;

    // Channel count and per-channel location codes on the low address lines.
    localparam int CHANNELS = 4;
    localparam logic [3:0] LOC_DATA = 4'h0;
    localparam logic [3:0] LOC_INT_EN = 4'h1;
    localparam logic [3:0] LOC_INT_STAT = 4'h2;
    localparam logic [3:0] LOC_LINE_CTL = 4'h3;
    localparam logic [3:0] LOC_MODEM_CTL = 4'h4;
    localparam logic [3:0] LOC_LINE_STAT = 4'h5;
    localparam logic [3:0] LOC_MODEM_STAT = 4'h6;
    localparam logic [3:0] LOC_SCRATCH = 4'h7;
    localparam logic [3:0] LOC_FEAT = 4'h8;
    localparam logic [3:0] LOC_ENH = 4'h9;
    localparam logic [3:0] LOC_TX_LVL = 4'hA;
    localparam logic [3:0] LOC_RX_LVL = 4'hB;
    localparam logic [3:0] LOC_OFF1 = 4'hC;
    localparam logic [3:0] LOC_OFF2 = 4'hD;
    localparam logic [3:0] LOC_ON1 = 4'hE;
    localparam logic [3:0] LOC_ON2 = 4'hF;

    // Device-wide locations, reached with the device select raised.
    localparam logic [3:0] DEV_IDENT = 4'h0;
    localparam logic [3:0] DEV_REVISION = 4'h1;
    localparam logic [3:0] DEV_BCAST = 4'h2;

    // Field positions and masks.
    localparam int DIV_ACCESS_BIT = 7;
    localparam int ENH_ENABLE_BIT = 4;
    localparam int BCAST_BIT = 0;
    localparam logic [7:0] FRAC_MASK = 8'h0F;
    localparam logic [7:0] FLAG_MASK = 8'h0F;
    localparam logic [7:0] INT_EN_ENH_MASK = 8'hE0;
    localparam logic [7:0] INT_STAT_ENH_MASK = 8'h30;
    localparam logic [7:0] FIFO_CTL_ENH_MASK = 8'h30;
    localparam logic [7:0] MODEM_CTL_ENH_MASK = 8'hEC;
    localparam logic [7:0] TURN_ENH_MASK = 8'hFC;

    // Reset values.
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic BCAST_RESET = 1'b0;

    typedef struct packed {
        logic [7:0] divisor_low, divisor_high, divisor_fraction, interrupt_enable;
        logic [7:0] line_control, modem_control, scratch_pad, feature_control;
        logic [7:0] enhanced_function, tx_fifo_trigger, rx_fifo_trigger;
        logic [7:0] turnaround_delay, flow_off_first, flow_off_second;
        logic [7:0] flow_on_first, flow_on_second;
    } ucr_cfg_t;

    typedef struct packed {
        logic [7:0] rx_holding, interrupt_status, line_status;
        logic [7:0] modem_status, tx_fifo_level, rx_fifo_level;
    } ucr_stat_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic dev_sel;
        logic [1:0] chan;
        logic [3:0] loc;
        logic [7:0] wdata;
    } ucr_host_t;

    typedef struct packed {
        logic [CHANNELS-1:0] tx_push;
        logic [CHANNELS-1:0] rx_pop;
        logic [CHANNELS-1:0] fifo_load;
        logic [7:0] fifo_value;
        logic [7:0] tx_byte;
    } ucr_strobe_t;

    typedef struct packed {
        ucr_cfg_t [CHANNELS-1:0] cfg;
        logic [CHANNELS-1:0][3:0] flags;
        logic bcast;
        logic [7:0] rd_data;
        logic rd_valid;
        ucr_strobe_t strobe;
    } ucr_state_t;

endpackage : ucr_pkg

// ===== verilog/ucr_decode.sv
// Notes on behaviour
// - Read-only identification byte returns a fixed device type code.
// - Read-only revision byte counts up by one per silicon revision.
// - Broadcast bit set: a channel write updates all four channels.
// - Broadcast bit clear, its reset value: only the addressed channel changes.
// - Four low address lines pick one of sixteen channel locations.
// - Lower eight locations are the classic set, upper eight the enhanced ones.
// - Location 0, divisor access clear: read receive byte, write transmit byte.
// - Divisor access set: locations 0-2 are divisor low, high, 4-bit fraction.
// - Location 1, divisor access clear: interrupt enable, read and write.
// - Location 2, divisor access clear: read interrupt status, write FIFO control.
// - Locations 3 and 4: line and modem control, always read and write.
// - Location 5 reads line status; writes there do nothing.
// - Location 6 reads modem status; writes set turnaround delay.
// - Location 7 is a scratch byte returning the last write.
// - Locations 8 and 9: feature control and enhanced function, read and write.
// - Location 10 reads transmit fill count, writes transmit trigger level.
// - Location 11 reads receive fill count, writes receive trigger level.
// - Location 12 writes first flow-off char, reads flow character flags.
// - Locations 13-15 hold further flow chars, write only; reads reserved.
// - Enhanced bits in several registers work only with enhanced bit 4 set.
// - Flow flags use low four bits and clear once read.
module ucr_decode #(
    parameter logic [7:0] IDENT_CODE = 8'hA5, // Arbitrary device type value.
    parameter logic [7:0] REVISION_CODE = 8'h11 // Arbitrary revision value.
) (
    input logic mclk,
    input logic resetn,
    input ucr_pkg::ucr_host_t host,
    input ucr_pkg::ucr_stat_t [ucr_pkg::CHANNELS-1:0] stat,
    input logic [ucr_pkg::CHANNELS-1:0][3:0] flow_event,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output ucr_pkg::ucr_cfg_t [ucr_pkg::CHANNELS-1:0] cfg,
    output logic broadcast_enable,
    output ucr_pkg::ucr_strobe_t strobe
);

    ucr_pkg::ucr_state_t st;
    ucr_pkg::ucr_state_t next_st;

    // Enhanced bits keep their old value unless the enhanced enable is set.
    function automatic logic [7:0] keep_enh(input logic [7:0] old, input logic [7:0] d,
                                            input logic [7:0] mask, input logic en);
        keep_enh = en ? d : ((old & mask) | (d & ~mask));
    endfunction : keep_enh

    // Applies one host write to one channel's configuration.
    function automatic ucr_pkg::ucr_cfg_t cfg_write(input ucr_pkg::ucr_cfg_t c,
                                                    input logic [3:0] loc,
                                                    input logic [7:0] d);
        ucr_pkg::ucr_cfg_t r;
        logic dl;
        logic en;
        r = c;
        dl = c.line_control[ucr_pkg::DIV_ACCESS_BIT];
        en = c.enhanced_function[ucr_pkg::ENH_ENABLE_BIT];
        case (loc)
            ucr_pkg::LOC_DATA: begin
                if (dl) begin
                    r.divisor_low = d;
                end
            end
            ucr_pkg::LOC_INT_EN: begin
                if (dl) begin
                    r.divisor_high = d;
                end else begin
                    r.interrupt_enable = keep_enh(c.interrupt_enable, d,
                        ucr_pkg::INT_EN_ENH_MASK, en);
                end
            end
            ucr_pkg::LOC_INT_STAT: begin
                if (dl) begin
                    r.divisor_fraction = d & ucr_pkg::FRAC_MASK;
                end
            end
            ucr_pkg::LOC_LINE_CTL: r.line_control = d;
            ucr_pkg::LOC_MODEM_CTL: begin
                r.modem_control = keep_enh(c.modem_control, d,
                    ucr_pkg::MODEM_CTL_ENH_MASK, en);
            end
            ucr_pkg::LOC_LINE_STAT: r = c;
            ucr_pkg::LOC_MODEM_STAT: begin
                r.turnaround_delay = keep_enh(c.turnaround_delay, d,
                    ucr_pkg::TURN_ENH_MASK, en);
            end
            ucr_pkg::LOC_SCRATCH: r.scratch_pad = d;
            ucr_pkg::LOC_FEAT: r.feature_control = d;
            ucr_pkg::LOC_ENH: r.enhanced_function = d;
            ucr_pkg::LOC_TX_LVL: r.tx_fifo_trigger = d;
            ucr_pkg::LOC_RX_LVL: r.rx_fifo_trigger = d;
            ucr_pkg::LOC_OFF1: r.flow_off_first = d;
            ucr_pkg::LOC_OFF2: r.flow_off_second = d;
            ucr_pkg::LOC_ON1: r.flow_on_first = d;
            ucr_pkg::LOC_ON2: r.flow_on_second = d;
        endcase
        cfg_write = r;
    endfunction : cfg_write

    // Read multiplexer for one channel; low half classic, high half enhanced.
    function automatic logic [7:0] chan_read(input ucr_pkg::ucr_cfg_t c,
                                             input ucr_pkg::ucr_stat_t s,
                                             input logic [3:0] flags,
                                             input logic [3:0] loc);
        logic dl;
        logic en;
        dl = c.line_control[ucr_pkg::DIV_ACCESS_BIT];
        en = c.enhanced_function[ucr_pkg::ENH_ENABLE_BIT];
        case (loc)
            ucr_pkg::LOC_DATA: chan_read = dl ? c.divisor_low : s.rx_holding;
            ucr_pkg::LOC_INT_EN: begin
                chan_read = dl ? c.divisor_high : (c.interrupt_enable
                    & ~(en ? 8'h00 : ucr_pkg::INT_EN_ENH_MASK));
            end
            ucr_pkg::LOC_INT_STAT: begin
                chan_read = dl ? (c.divisor_fraction & ucr_pkg::FRAC_MASK)
                    : (s.interrupt_status
                    & ~(en ? 8'h00 : ucr_pkg::INT_STAT_ENH_MASK));
            end
            ucr_pkg::LOC_LINE_CTL: chan_read = c.line_control;
            ucr_pkg::LOC_MODEM_CTL: chan_read = c.modem_control;
            ucr_pkg::LOC_LINE_STAT: chan_read = s.line_status;
            ucr_pkg::LOC_MODEM_STAT: chan_read = s.modem_status;
            ucr_pkg::LOC_SCRATCH: chan_read = c.scratch_pad;
            ucr_pkg::LOC_FEAT: chan_read = c.feature_control;
            ucr_pkg::LOC_ENH: chan_read = c.enhanced_function;
            ucr_pkg::LOC_TX_LVL: chan_read = s.tx_fifo_level;
            ucr_pkg::LOC_RX_LVL: chan_read = s.rx_fifo_level;
            ucr_pkg::LOC_OFF1: chan_read = {4'h0, flags} & ucr_pkg::FLAG_MASK;
            default: chan_read = 8'h00;
        endcase
    endfunction : chan_read

    // Next-state logic: strobes default low, flags gather events, then the
    // host read and write are applied. A flag event in the clearing read's
    // cycle survives, because the clear drops only the old flags.
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.strobe.tx_push = '0;
        next_st.strobe.rx_pop = '0;
        next_st.strobe.fifo_load = '0;
        for (int c = 0; c < ucr_pkg::CHANNELS; c++) begin
            next_st.flags[c] = st.flags[c] | flow_event[c];
        end
        if (host.rd) begin
            next_st.rd_valid = 1'b1;
            if (host.dev_sel) begin
                case (host.loc)
                    ucr_pkg::DEV_IDENT: next_st.rd_data = IDENT_CODE;
                    ucr_pkg::DEV_REVISION: next_st.rd_data = REVISION_CODE;
                    ucr_pkg::DEV_BCAST: next_st.rd_data = {7'h00, st.bcast};
                    default: next_st.rd_data = 8'h00;
                endcase
            end else begin
                // Only the addressed channel answers a read.
                next_st.rd_data = chan_read(st.cfg[host.chan], stat[host.chan],
                    st.flags[host.chan], host.loc);
                if (host.loc == ucr_pkg::LOC_OFF1) begin
                    next_st.flags[host.chan] = flow_event[host.chan];
                end
                if (host.loc == ucr_pkg::LOC_DATA
                    && !st.cfg[host.chan].line_control[ucr_pkg::DIV_ACCESS_BIT]) begin
                    next_st.strobe.rx_pop[host.chan] = 1'b1;
                end
            end
        end
        if (host.wr) begin
            if (host.dev_sel) begin
                if (host.loc == ucr_pkg::DEV_BCAST) begin
                    next_st.bcast = host.wdata[ucr_pkg::BCAST_BIT];
                end
            end else begin
                for (int c = 0; c < ucr_pkg::CHANNELS; c++) begin
                    if (st.bcast || host.chan == 2'(c)) begin
                        next_st.cfg[c] = cfg_write(st.cfg[c], host.loc, host.wdata);
                        if (!st.cfg[c].line_control[ucr_pkg::DIV_ACCESS_BIT]) begin
                            if (host.loc == ucr_pkg::LOC_DATA) begin
                                next_st.strobe.tx_push[c] = 1'b1;
                            end
                            if (host.loc == ucr_pkg::LOC_INT_STAT) begin
                                next_st.strobe.fifo_load[c] = 1'b1;
                            end
                        end
                    end
                end
                next_st.strobe.tx_byte = host.wdata;
                // Shared value; with broadcast the addressed channel's gate rules.
                next_st.strobe.fifo_value = host.wdata & ~(st.cfg[host.chan]
                    .enhanced_function[ucr_pkg::ENH_ENABLE_BIT] ? 8'h00
                    : ucr_pkg::FIFO_CTL_ENH_MASK);
            end
        end
    end

    // State register; reset gives every configuration byte its reset value.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            for (int c = 0; c < ucr_pkg::CHANNELS; c++) begin
                st.cfg[c] <= {16{ucr_pkg::CFG_RESET}};
            end
            st.bcast <= ucr_pkg::BCAST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign rd_data = st.rd_data;
    assign rd_valid = st.rd_valid;
    assign cfg = st.cfg;
    assign broadcast_enable = st.bcast;
    assign strobe = st.strobe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Every read answers on the next edge, and nothing else raises the valid pulse.
    AST_READ_VALID: assert property (host.rd |=> rd_valid)
        else $error("Read did not answer one cycle later.");
    AST_READ_IDLE: assert property (!host.rd |=> !rd_valid)
        else $error("Valid pulse without a read.");
    AST_IDENT: assert property (host.rd && host.dev_sel && host.loc == ucr_pkg::DEV_IDENT
        |=> rd_data == IDENT_CODE)
        else $error("Identification read returned wrong code.");
    AST_REVISION: assert property (host.rd && host.dev_sel
        && host.loc == ucr_pkg::DEV_REVISION |=> rd_data == REVISION_CODE)
        else $error("Revision read returned wrong code.");
    AST_BCAST_ALL: assert property (host.wr && !host.dev_sel && st.bcast
        && host.loc == ucr_pkg::LOC_SCRATCH |=> cfg[0].scratch_pad == $past(host.wdata)
        && cfg[ucr_pkg::CHANNELS-1].scratch_pad == $past(host.wdata))
        else $error("Broadcast write missed a channel.");
    AST_SINGLE: assert property (host.wr && !host.dev_sel && !st.bcast
        && host.chan != 2'h0 |=> $stable(cfg[0]))
        else $error("Single write disturbed another channel.");
    AST_FRAC_HIGH: assert property (cfg[0].divisor_fraction[7:4] == 4'h0)
        else $error("Fraction upper bits not zero.");
    AST_FLAG_CLEAR: assert property (host.rd && !host.dev_sel && host.chan == 2'h0
        && host.loc == ucr_pkg::LOC_OFF1 && flow_event[0] == 4'h0 |=> st.flags[0] == 4'h0)
        else $error("Flow flags not cleared by read.");
    // An event in the clearing read's own cycle must not be lost to the clear.
    AST_FLAG_SET_WINS: assert property (host.rd && !host.dev_sel
        && host.chan == 2'h0 && host.loc == ucr_pkg::LOC_OFF1 && flow_event[0] != 4'h0
        |=> st.flags[0] == $past(flow_event[0]))
        else $error("Flow flag event lost in a clearing read.");
    AST_FLAG_HIGH: assert property (host.rd && !host.dev_sel
        && host.loc == ucr_pkg::LOC_OFF1 |=> rd_data[7:4] == 4'h0)
        else $error("Flow flag read has upper bits set.");
    AST_TX_PUSH: assert property (host.wr && !host.dev_sel && !st.bcast
        && host.loc == ucr_pkg::LOC_DATA
        && !st.cfg[host.chan].line_control[ucr_pkg::DIV_ACCESS_BIT]
        |=> strobe.tx_push == 4'(4'h1 << $past(host.chan))
        && strobe.tx_byte == $past(host.wdata))
        else $error("Transmit push missing or misdirected.");
    // A receive byte read pops only the addressed channel.
    AST_RX_POP: assert property (host.rd && !host.dev_sel
        && host.loc == ucr_pkg::LOC_DATA
        && !st.cfg[host.chan].line_control[ucr_pkg::DIV_ACCESS_BIT]
        |=> strobe.rx_pop == 4'(4'h1 << $past(host.chan)))
        else $error("Receive pop missing or misdirected.");
    // With divisor access set, location 0 is the divisor and must not drain the receiver.
    AST_DIV_LOW: assert property (host.rd && !host.dev_sel
        && host.loc == ucr_pkg::LOC_DATA
        && st.cfg[host.chan].line_control[ucr_pkg::DIV_ACCESS_BIT]
        |=> rd_data == $past(st.cfg[host.chan].divisor_low) && strobe.rx_pop == 4'h0)
        else $error("Divisor low read wrong or popped the receiver.");
    AST_LINE_STAT_WR: assert property (host.wr && !host.dev_sel
        && host.loc == ucr_pkg::LOC_LINE_STAT |=> $stable(cfg))
        else $error("Write to line status location changed a register.");
    AST_ENH_GATED: assert property (host.wr && !host.dev_sel && !st.bcast
        && host.chan == 2'h0 && host.loc == ucr_pkg::LOC_INT_EN
        && !st.cfg[0].line_control[ucr_pkg::DIV_ACCESS_BIT]
        && !st.cfg[0].enhanced_function[ucr_pkg::ENH_ENABLE_BIT]
        |=> $stable(cfg[0].interrupt_enable[7:5]))
        else $error("Enhanced enable bits changed while gated.");
    AST_BCAST_READ: assert property (host.rd && host.dev_sel
        && host.loc == ucr_pkg::DEV_BCAST |=> rd_data == {7'h00, $past(broadcast_enable)})
        else $error("Broadcast control read wrong.");
    AST_RESERVED_READ: assert property (host.rd && !host.dev_sel
        && host.loc == ucr_pkg::LOC_ON2 |=> rd_data == 8'h00 && rd_valid)
        else $error("Reserved read not zero.");

endmodule : ucr_decode

// ===== tb/ucr_host_model.sv
module ucr_host_model (
    input wire logic mclk,
    output ucr_pkg::ucr_host_t host,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus starts idle so that nothing is taken while reset is released.
    initial begin
        host = '0;
    end

    // One access, launched after an edge and taken at the next one.
    // The write byte is inverted on release so stale data is never mistaken for live data.
    task automatic access(input logic dev, input logic [1:0] c, input logic [3:0] l,
                          input logic is_rd, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(posedge mclk);
        host <= '{rd: is_rd, wr: !is_rd, dev_sel: dev, chan: c, loc: l, wdata: d};
        @(posedge mclk);
        host.rd <= 1'b0;
        host.wr <= 1'b0;
        host.wdata <= ~d;
        #1;
        q = rd_data;
        v = rd_valid;
    endtask : access
endmodule : ucr_host_model

// ===== tb/uart_channel_register_decode_test.sv
`define UCR_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH at %0t: value %0h differs from %0h", $time, got, exp); end end

module uart_channel_register_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary identification value.
    localparam logic [7:0] REV_VAL = 8'h03; // Arbitrary revision value.
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ucr_pkg::ucr_host_t host;
    ucr_pkg::ucr_stat_t [3:0] stat = '0;
    logic [3:0][3:0] flow_event = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    ucr_pkg::ucr_cfg_t [3:0] cfg;
    ucr_pkg::ucr_cfg_t [3:0] snap;
    logic broadcast_enable;
    ucr_pkg::ucr_strobe_t strobe;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed = 21;
    logic [7:0] q;
    logic v;
    logic [7:0] d;
    logic [7:0] w;

    ucr_decode #(.IDENT_CODE(ID_VAL), .REVISION_CODE(REV_VAL)) u_dut (.mclk(mclk),
        .resetn(resetn), .host(host), .stat(stat), .flow_event(flow_event),
        .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg),
        .broadcast_enable(broadcast_enable), .strobe(strobe));
    ucr_host_model u_host (.mclk(mclk), .host(host), .rd_data(rd_data), .rd_valid(rd_valid));

    // Free-running clock and a cycle ceiling well above the several hundred cycles needed.
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Checks made: %0d, mismatches: %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Writes keep a copy of the whole configuration so side effects can be spotted.
    task automatic wr(input logic dev, input logic [1:0] c, input logic [3:0] l,
                      input logic [7:0] dd);
        snap = cfg;
        u_host.access(dev, c, l, 1'b0, dd, q, v);
    endtask : wr

    task automatic rd(input logic dev, input logic [1:0] c, input logic [3:0] l);
        u_host.access(dev, c, l, 1'b1, 8'h00, q, v);
        `UCR_CHK(v, 1'b1)
    endtask : rd

    // Bits that survive a write while the enhanced gate is open or closed.
    function automatic logic [7:0] wmask(input logic [3:0] l, input logic e);
        case (l)
            4'h1: wmask = e ? 8'hFF : ~ucr_pkg::INT_EN_ENH_MASK;
            4'h2: wmask = e ? 8'hFF : ~ucr_pkg::FIFO_CTL_ENH_MASK;
            4'h4: wmask = e ? 8'hFF : ~ucr_pkg::MODEM_CTL_ENH_MASK;
            4'h6: wmask = e ? 8'hFF : ~ucr_pkg::TURN_ENH_MASK;
            default: wmask = 8'hFF;
        endcase
    endfunction : wmask

    function automatic logic [7:0] cfg_of(input int c, input logic [3:0] l);
        case (l)
            4'h0: cfg_of = strobe.tx_byte;
            4'h1: cfg_of = cfg[c].interrupt_enable;
            4'h2: cfg_of = strobe.fifo_value;
            4'h3: cfg_of = cfg[c].line_control;
            4'h4: cfg_of = cfg[c].modem_control;
            4'h6: cfg_of = cfg[c].turnaround_delay;
            4'h7: cfg_of = cfg[c].scratch_pad;
            4'h8: cfg_of = cfg[c].feature_control;
            4'hA: cfg_of = cfg[c].tx_fifo_trigger;
            4'hB: cfg_of = cfg[c].rx_fifo_trigger;
            4'hC: cfg_of = cfg[c].flow_off_first;
            4'hD: cfg_of = cfg[c].flow_off_second;
            4'hE: cfg_of = cfg[c].flow_on_first;
            default: cfg_of = cfg[c].flow_on_second;
        endcase
    endfunction : cfg_of

    // Read answer with the divisor latches hidden and no flow flags pending.
    function automatic logic [7:0] exp_rd(input int c, input logic [3:0] l, input logic e,
                                          input logic [7:0] lw);
        case (l)
            4'h0: exp_rd = stat[c].rx_holding;
            4'h1, 4'h3, 4'h4, 4'h7, 4'h8: exp_rd = lw;
            4'h2: exp_rd = stat[c].interrupt_status & (e ? 8'hFF : ~ucr_pkg::INT_STAT_ENH_MASK);
            4'h5: exp_rd = stat[c].line_status;
            4'h6: exp_rd = stat[c].modem_status;
            4'hA: exp_rd = stat[c].tx_fifo_level;
            4'hB: exp_rd = stat[c].rx_fifo_level;
            default: exp_rd = 8'h00;
        endcase
    endfunction : exp_rd

    // Main sequence: reset, channel map sweep, divisor, flags, device-wide registers,
    // then a second reset in mid-run.
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        for (int c = 0; c < 4; c++) stat[c] <= 48'({$random(seed), $random(seed)});
        @(posedge mclk);
        #1;
        `UCR_CHK(cfg, '0)
        `UCR_CHK(broadcast_enable, 1'b0)
        for (int c = 0; c < 4; c++) begin
            for (int e = 0; e < 2; e++) begin
                wr(1'b0, 2'(c), 4'h9, 8'(e) << ucr_pkg::ENH_ENABLE_BIT);
                rd(1'b0, 2'(c), 4'h9);
                `UCR_CHK(q, 8'(e) << ucr_pkg::ENH_ENABLE_BIT)
                for (int l = 0; l < 16; l++) begin
                    if (l == 9) continue;
                    d = 8'($random(seed));
                    if (l == 3) d[7] = 1'b0;
                    wr(1'b0, 2'(c), 4'(l), d);
                    w = d & wmask(4'(l), e[0]);
                    if (l != 5) `UCR_CHK(cfg_of(c, 4'(l)), w)
                    else `UCR_CHK(cfg, snap)
                    if (l == 0) `UCR_CHK(strobe.tx_push, 4'(1 << c))
                    if (l == 2) `UCR_CHK(strobe.fifo_load, 4'(1 << c))
                    for (int o = 0; o < 4; o++) if (o != c) `UCR_CHK(cfg[o], snap[o])
                    rd(1'b0, 2'(c), 4'(l));
                    `UCR_CHK(q, exp_rd(c, 4'(l), e[0], w))
                    if (l == 0) `UCR_CHK(strobe.rx_pop, 4'(1 << c))
                end
            end
            wr(1'b0, 2'(c), 4'h3, 8'h80);
            for (int l = 0; l < 3; l++) begin
                d = 8'($random(seed));
                wr(1'b0, 2'(c), 4'(l), d);
                `UCR_CHK(strobe.tx_push, 4'h0)
                rd(1'b0, 2'(c), 4'(l));
                `UCR_CHK(q, (l == 2) ? (d & ucr_pkg::FRAC_MASK) : d)
            end
            wr(1'b0, 2'(c), 4'h3, 8'h00);
            d = 8'($random(seed));
            @(posedge mclk);
            flow_event[c] <= d[3:0] | 4'h1;
            @(posedge mclk);
            flow_event <= '0;
            rd(1'b0, 2'(c), 4'hC);
            `UCR_CHK(q, {4'h0, d[3:0] | 4'h1})
            // An event arriving with the clearing read must outlive that read.
            fork
                rd(1'b0, 2'(c), 4'hC);
                begin
                    @(posedge mclk);
                    flow_event[c] <= 4'h5;
                    @(posedge mclk);
                    flow_event <= '0;
                end
            join
            `UCR_CHK(q, 8'h00)
            rd(1'b0, 2'(c), 4'hC);
            `UCR_CHK(q, 8'h05)
            rd(1'b0, 2'(c), 4'hC);
            `UCR_CHK(q, 8'h00)
        end
        rd(1'b1, 2'd0, ucr_pkg::DEV_IDENT);
        `UCR_CHK(q, ID_VAL)
        rd(1'b1, 2'd0, ucr_pkg::DEV_REVISION);
        `UCR_CHK(q, REV_VAL)
        rd(1'b1, 2'd0, 4'h3);
        `UCR_CHK(q, 8'h00)
        wr(1'b1, 2'd0, ucr_pkg::DEV_BCAST, 8'hFF);
        `UCR_CHK(broadcast_enable, 1'b1)
        rd(1'b1, 2'd0, ucr_pkg::DEV_BCAST);
        `UCR_CHK(q, 8'h01)
        // Bit 0 set keeps the broadcast byte apart from the later single write.
        d = 8'($random(seed)) | 8'h01;
        wr(1'b0, 2'd2, 4'h7, d);
        for (int o = 0; o < 4; o++) `UCR_CHK(cfg[o].scratch_pad, d)
        wr(1'b1, 2'd0, ucr_pkg::DEV_BCAST, 8'h00);
        wr(1'b0, 2'd0, 4'h7, 8'h3C);
        `UCR_CHK(cfg[1].scratch_pad, d)
        wr(1'b1, 2'd0, ucr_pkg::DEV_BCAST, 8'h01);
        rd(1'b0, 2'd0, 4'h7);
        `UCR_CHK(q, 8'h3C)
        rd(1'b0, 2'd1, 4'h7);
        `UCR_CHK(q, d)
        // A reset in mid-run must drop broadcast and every configuration byte.
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `UCR_CHK(broadcast_enable, 1'b0)
        `UCR_CHK(cfg, '0)
        @(posedge mclk);
        resetn <= 1'b1;
        rd(1'b1, 2'd0, ucr_pkg::DEV_BCAST);
        `UCR_CHK(q, 8'h00)
        rd(1'b0, 2'd1, 4'h7);
        `UCR_CHK(q, 8'h00)
        close_out();
    end
endmodule : uart_channel_register_decode_test
